// ===== pkg/ocfs_defs.svh
`ifndef OCFS_DEFS_SVH
`define OCFS_DEFS_SVH

// ----------------------------------------
// Widths
// ----------------------------------------
`define OCFS_KHZ_W        20
`define OCFS_NRAT         11

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define OCFS_OFF_MAIN     8'h00
`define OCFS_OFF_AUX      8'h04
`define OCFS_OFF_OUT0     8'h08
`define OCFS_OFF_OUT1     8'h0c
`define OCFS_OFF_OUT2     8'h10
`define OCFS_OFF_OUT3     8'h14
`define OCFS_OFF_ALT      8'h18
`define OCFS_OFF_MISC6    8'h1c
`define OCFS_OFF_MISC7    8'h20
`define OCFS_OFF_STAT     8'h24
`define OCFS_OFF_MAINKHZ  8'h28
`define OCFS_OFF_AUXKHZ   8'h2c
`define OCFS_OFF_SYNAKHZ  8'h30
`define OCFS_OFF_SYNBKHZ  8'h34

// ----------------------------------------
// Field positions
// ----------------------------------------
`define OCFS_F_MAINFREQ   2:0
`define OCFS_F_M2A        5:3
`define OCFS_F_LOCK       6
`define OCFS_F_AUXFREQ    3:0
`define OCFS_F_OLO        3:0
`define OCFS_F_OHI        7:4
`define OCFS_F_ALT        6:0
`define OCFS_F_AFAM       0
`define OCFS_F_BFAM       1
`define OCFS_F_BALT       2
`define OCFS_F_AMUL       1:0
`define OCFS_F_BMUL       3:2
`define OCFS_F_SEN        6:0
`define OCFS_F_SPD        7
`define OCFS_F_SOK        14:8

// ----------------------------------------
// Frequencies in kHz
// ----------------------------------------
`define OCFS_K311040      20'h4bf00
`define OCFS_K98304       20'h18000
`define OCFS_K131072      20'h20000
`define OCFS_K148224      20'h24300
`define OCFS_K98816       20'h18200
`define OCFS_K100992      20'h18a80
`define OCFS_K250000      20'h3d090
`define OCFS_K274944      20'h43200
`define OCFS_K178944      20'h2bb00
`define OCFS_K122880      20'h1e000
`define OCFS_K160000      20'h27100
`define OCFS_K104000      20'h19640
`define OCFS_K312500      20'h4c4b4
`define OCFS_K2048        20'h00800
`define OCFS_K1544        20'h00608
`define OCFS_K6312        20'h018a8
`define OCFS_K10000       20'h02710
`define OCFS_K19440       20'h04bf0
`define OCFS_K38880       20'h097e0
`define OCFS_KOFF         20'h00000

// ----------------------------------------
// Divider ratio masks, bit order /2 /4 /5 /6 /8 /10 /12 /16 /20 /48 /64
// ----------------------------------------
`define OCFS_M_ALL        11'h7ff
`define OCFS_M_A          11'h6db
`define OCFS_M_B          11'h137
`define OCFS_M_C          11'h5b7
`define OCFS_M_D          11'h493
`define OCFS_M_E          11'h1b7
`define OCFS_M_F          11'h025
`define OCFS_M_NONE       11'h000
`define OCFS_R4           4'h1
`define OCFS_R6           4'h3
`define OCFS_R8           4'h4
`define OCFS_R12          4'h6
`define OCFS_R16          4'h7
`define OCFS_R48          4'h9
`define OCFS_R64          4'ha

`endif

// ===== pkg/ocfs_pkg.sv
`include "ocfs_defs.svh"

package ocfs_pkg;

	// ----------------------------------------
	// Whole state of the block
	// ----------------------------------------
	typedef struct packed {
		logic [2:0]             main_freq;     // Main APLL code
		logic [2:0]             m2a_freq;      // Coupled aux code
		logic                   lock;          // Aux APLL locked to main
		logic [3:0]             aux_freq;      // Aux APLL code
		logic [27:0]            ofreq;         // Seven 4-bit output fields
		logic [6:0]             alt;           // Alternate-table bits
		logic                   a_fam;         // Synth A family
		logic                   b_fam;         // Synth B family
		logic                   b_alt;         // Synth B alternate set
		logic [1:0]             a_mul;         // Synth A multiplier
		logic [1:0]             b_mul;         // Synth B multiplier
		logic                   wr_pend;       // Write data phase due
		logic [7:0]             wr_addr;       // Write byte address
		logic [31:0]            hrdata;        // Read data
		logic                   hready;        // Ready out
		logic [6:0]             out_en;        // Output enables
		logic [6:0]             freq_ok;       // Divider legal for APLL
		logic                   aux_pd;        // Aux APLL powered down
		logic [`OCFS_KHZ_W-1:0] main_khz;
		logic [`OCFS_KHZ_W-1:0] main_dfs_khz;
		logic [`OCFS_KHZ_W-1:0] aux_khz;
		logic [`OCFS_KHZ_W-1:0] aux_dfs_khz;
		logic [`OCFS_KHZ_W-1:0] apll2_khz;
		logic [`OCFS_KHZ_W-1:0] syn_a_khz;
		logic [`OCFS_KHZ_W-1:0] syn_b_khz;
	} ocfs_state_s;

endpackage

// ===== core/ocfs_top.sv
// How it works
// R1 - Coupling bit picks aux APLL reference
// R2 - One frequency set per APLL
// R3 - Main code sets main APLL frequency
// R4 - Main DFS runs at quarter APLL
// R5 - Software programs aux and coupling fields
// R6 - Output field plus alternate bit select
// R7 - Synth A multiplier and family choose frequency
// R8 - Synth B alternate bit adds four rates
// R9 - Only listed divide ratios are valid
// R10 - Second main APLL fixed at 312.5
// R11 - Aux off powers down, drives outputs low
// R12 - Output code zero disables output
// R13 - Software sets APLLs before outputs
//
// The implementer's own choices: the address map and register access over AHB-Lite.
`timescale 1ns/1ps
`include "ocfs_defs.svh"

module ocfs_top #(
	parameter int NOUT = 7
) (
	// Clock and reset
	input  wire logic                   hclk,
	input  wire logic                   hresetn,
	// AHB-Lite slave
	input  wire logic                   hsel,
	input  wire logic [31:0]            haddr,
	input  wire logic [1:0]             htrans,
	input  wire logic                   hwrite,
	input  wire logic [2:0]             hsize,
	input  wire logic [31:0]            hwdata,
	input  wire logic                   hready,
	output logic                        hreadyout,
	output logic                        hresp,
	output logic      [31:0]            hrdata,
	// Output clock control
	output logic      [NOUT-1:0]        out_enable,
	output logic      [NOUT-1:0]        out_freq_ok,
	output logic                        aux_apll_power_down,
	// Decoded frequencies in kHz
	output logic      [`OCFS_KHZ_W-1:0] main_apll_khz,
	output logic      [`OCFS_KHZ_W-1:0] main_dfs_khz,
	output logic      [`OCFS_KHZ_W-1:0] aux_apll_khz,
	output logic      [`OCFS_KHZ_W-1:0] aux_dfs_khz,
	output logic      [`OCFS_KHZ_W-1:0] apll2_khz,
	output logic      [`OCFS_KHZ_W-1:0] synth_a_khz,
	output logic      [`OCFS_KHZ_W-1:0] synth_b_khz
);

	// ----------------------------------------
	// Decode functions
	// ----------------------------------------

	// Main APLL frequency per code
	function automatic logic [`OCFS_KHZ_W-1:0] main_khz_f(input logic [2:0] c);
		unique case (c)
			3'h0, 3'h1: main_khz_f = `OCFS_K311040;
			3'h2:       main_khz_f = `OCFS_K98304;
			3'h3:       main_khz_f = `OCFS_K131072;
			3'h4:       main_khz_f = `OCFS_K148224;
			3'h5:       main_khz_f = `OCFS_K98816;
			3'h6:       main_khz_f = `OCFS_K100992;
			3'h7:       main_khz_f = `OCFS_K250000;
		endcase
	endfunction

	// Aux APLL frequency; coupled codes 3 and 5 are unused and give off
	function automatic logic [`OCFS_KHZ_W-1:0] aux_khz_f(input logic lk,
			input logic [2:0] m, input logic [3:0] f);
		aux_khz_f = `OCFS_KOFF;
		if (lk) begin
			unique case (m)
				3'h0:    aux_khz_f = `OCFS_K98304;
				3'h1:    aux_khz_f = `OCFS_K250000;
				3'h2:    aux_khz_f = `OCFS_K131072;
				3'h4:    aux_khz_f = `OCFS_K148224;
				3'h6:    aux_khz_f = `OCFS_K98816;
				3'h7:    aux_khz_f = `OCFS_K100992;
				default: aux_khz_f = `OCFS_KOFF;
			endcase
		end else begin
			unique case (f)
				4'h1:    aux_khz_f = `OCFS_K311040;
				4'h2:    aux_khz_f = `OCFS_K98304;
				4'h3:    aux_khz_f = `OCFS_K131072;
				4'h4:    aux_khz_f = `OCFS_K148224;
				4'h5:    aux_khz_f = `OCFS_K98816;
				4'h6:    aux_khz_f = `OCFS_K274944;
				4'h7:    aux_khz_f = `OCFS_K178944;
				4'h8:    aux_khz_f = `OCFS_K100992;
				4'h9:    aux_khz_f = `OCFS_K250000;
				4'ha:    aux_khz_f = `OCFS_K122880;
				4'hb:    aux_khz_f = `OCFS_K160000;
				4'hc:    aux_khz_f = `OCFS_K104000;
				default: aux_khz_f = `OCFS_KOFF;
			endcase
		end
	endfunction

	// Legal divide ratios for an APLL frequency
	function automatic logic [`OCFS_NRAT-1:0] ratio_mask_f(input logic [`OCFS_KHZ_W-1:0] k);
		unique case (k)
			`OCFS_K311040, `OCFS_K122880:                 ratio_mask_f = `OCFS_M_ALL;
			`OCFS_K274944, `OCFS_K178944, `OCFS_K148224,
			`OCFS_K100992, `OCFS_K98304:                  ratio_mask_f = `OCFS_M_A;
			`OCFS_K250000:                                ratio_mask_f = `OCFS_M_B;
			`OCFS_K160000:                                ratio_mask_f = `OCFS_M_C;
			`OCFS_K131072, `OCFS_K98816:                  ratio_mask_f = `OCFS_M_D;
			`OCFS_K104000:                                ratio_mask_f = `OCFS_M_E;
			`OCFS_K312500:                                ratio_mask_f = `OCFS_M_F;
			default:                                      ratio_mask_f = `OCFS_M_NONE;
		endcase
	endfunction

	// Ratio index for a main-fed code in the primary table
	function automatic logic [3:0] main_ratio_f(input logic [3:0] c);
		unique case (c)
			4'h5:    main_ratio_f = `OCFS_R48;
			4'h6:    main_ratio_f = `OCFS_R16;
			4'h7:    main_ratio_f = `OCFS_R12;
			4'h8:    main_ratio_f = `OCFS_R8;
			4'h9:    main_ratio_f = `OCFS_R6;
			default: main_ratio_f = `OCFS_R4;
		endcase
	endfunction

	// Ratio index for an aux-fed code in the primary table
	function automatic logic [3:0] aux_ratio_f(input logic [3:0] c);
		unique case (c)
			4'hb:    aux_ratio_f = `OCFS_R64;
			4'hc:    aux_ratio_f = `OCFS_R48;
			4'hd:    aux_ratio_f = `OCFS_R16;
			4'he:    aux_ratio_f = `OCFS_R8;
			default: aux_ratio_f = `OCFS_R4;
		endcase
	endfunction

	// Synth A/B base rate times multiplier
	function automatic logic [`OCFS_KHZ_W-1:0] synth_f(input logic fam, input logic [1:0] mul);
		synth_f = (fam ? `OCFS_K1544 : `OCFS_K2048) << mul;
	endfunction

	// ----------------------------------------
	// State
	// ----------------------------------------
	localparam ocfs_pkg::ocfs_state_s RST_S = '{hready: 1'b1, default: '0};

	ocfs_pkg::ocfs_state_s st_r;   // Registered state
	ocfs_pkg::ocfs_state_s st_nxt; // Next state

	logic [3:0] code;              // Per-output code in the loop
	logic       aux_fed;           // Output drawn from aux APLL
	logic       main_fed;          // Output drawn from main APLL
	logic [3:0] ridx;              // Ratio index of that output
	logic [`OCFS_NRAT-1:0] mmask;  // Main APLL legal ratios
	logic [`OCFS_NRAT-1:0] amask;  // Aux APLL legal ratios

	// ----------------------------------------
	// Next-state logic
	// ----------------------------------------
	always_comb begin
		st_nxt   = st_r;
		code     = 4'h0;
		aux_fed  = 1'b0;
		main_fed = 1'b0;
		ridx     = 4'h0;
		// Bus data phase: write lands with hwdata; sizes other than word are
		// written as words since the master only issues whole words
		if (st_r.wr_pend) begin
			unique case (st_r.wr_addr)
				`OCFS_OFF_MAIN: begin
					st_nxt.main_freq = hwdata[`OCFS_F_MAINFREQ]; // R3
					st_nxt.m2a_freq  = hwdata[`OCFS_F_M2A];      // R5
					st_nxt.lock      = hwdata[`OCFS_F_LOCK];     // R1
				end
				`OCFS_OFF_AUX:   st_nxt.aux_freq = hwdata[`OCFS_F_AUXFREQ]; // R5
				`OCFS_OFF_OUT0:  st_nxt.ofreq[7:0]   = hwdata[7:0];         // R6
				`OCFS_OFF_OUT1:  st_nxt.ofreq[15:8]  = hwdata[7:0];
				`OCFS_OFF_OUT2:  st_nxt.ofreq[23:16] = hwdata[7:0];
				`OCFS_OFF_OUT3:  st_nxt.ofreq[27:24] = hwdata[`OCFS_F_OLO];
				`OCFS_OFF_ALT:   st_nxt.alt = hwdata[`OCFS_F_ALT];          // R6
				`OCFS_OFF_MISC6: begin
					st_nxt.a_fam = hwdata[`OCFS_F_AFAM];
					st_nxt.b_fam = hwdata[`OCFS_F_BFAM];
					st_nxt.b_alt = hwdata[`OCFS_F_BALT];
				end
				`OCFS_OFF_MISC7: begin
					st_nxt.a_mul = hwdata[`OCFS_F_AMUL];
					st_nxt.b_mul = hwdata[`OCFS_F_BMUL];
				end
				default: ;  // Read-only or unmapped: ignored
			endcase
		end
		// Address phase capture; zero wait, response always OKAY
		st_nxt.wr_pend = hsel && htrans[1] && hready && hwrite;
		st_nxt.wr_addr = haddr[7:0];
		st_nxt.hready  = 1'b1;
		if (hsel && htrans[1] && hready && !hwrite) begin
			unique case (haddr[7:0])
				`OCFS_OFF_MAIN:    st_nxt.hrdata = {25'h0, st_r.lock, st_r.m2a_freq,
					st_r.main_freq};
				`OCFS_OFF_AUX:     st_nxt.hrdata = {28'h0, st_r.aux_freq};
				`OCFS_OFF_OUT0:    st_nxt.hrdata = {24'h0, st_r.ofreq[7:0]};
				`OCFS_OFF_OUT1:    st_nxt.hrdata = {24'h0, st_r.ofreq[15:8]};
				`OCFS_OFF_OUT2:    st_nxt.hrdata = {24'h0, st_r.ofreq[23:16]};
				`OCFS_OFF_OUT3:    st_nxt.hrdata = {28'h0, st_r.ofreq[27:24]};
				`OCFS_OFF_ALT:     st_nxt.hrdata = {25'h0, st_r.alt};
				`OCFS_OFF_MISC6:   st_nxt.hrdata = {29'h0, st_r.b_alt, st_r.b_fam, st_r.a_fam};
				`OCFS_OFF_MISC7:   st_nxt.hrdata = {28'h0, st_r.b_mul, st_r.a_mul};
				`OCFS_OFF_STAT:    st_nxt.hrdata = {17'h0, st_r.freq_ok, st_r.aux_pd,
					st_r.out_en};
				`OCFS_OFF_MAINKHZ: st_nxt.hrdata = {12'h0, st_r.main_khz};
				`OCFS_OFF_AUXKHZ:  st_nxt.hrdata = {12'h0, st_r.aux_khz};
				`OCFS_OFF_SYNAKHZ: st_nxt.hrdata = {12'h0, st_r.syn_a_khz};
				`OCFS_OFF_SYNBKHZ: st_nxt.hrdata = {12'h0, st_r.syn_b_khz};
				default:           st_nxt.hrdata = 32'h0;  // Unmapped reads zero
			endcase
		end
		// APLL decode, one cycle behind the configuration
		st_nxt.main_khz     = main_khz_f(st_r.main_freq);                    // R3
		st_nxt.main_dfs_khz = st_r.main_khz >> 2;                            // R4
		st_nxt.aux_khz      = aux_khz_f(st_r.lock, st_r.m2a_freq, st_r.aux_freq); // R1
		st_nxt.aux_dfs_khz  = st_r.aux_khz >> 2;
		st_nxt.apll2_khz    = `OCFS_K312500;                                 // R10
		st_nxt.aux_pd       = (st_r.aux_freq == 4'h0) && !st_r.lock;         // R11
		// Digital synthesizers
		st_nxt.syn_a_khz = synth_f(st_r.a_fam, st_r.a_mul);                  // R7
		if (!st_r.b_alt) begin
			st_nxt.syn_b_khz = synth_f(st_r.b_fam, st_r.b_mul);              // R8
		end else begin
			unique case ({st_r.b_mul, st_r.b_fam})
				3'b000:  st_nxt.syn_b_khz = `OCFS_K6312;                     // R8
				3'b100:  st_nxt.syn_b_khz = `OCFS_K10000;
				3'b001:  st_nxt.syn_b_khz = `OCFS_K19440;
				3'b011:  st_nxt.syn_b_khz = `OCFS_K38880;
				default: st_nxt.syn_b_khz = `OCFS_KOFF;  // Undefined combination
			endcase
		end
		// Per-output enable and divider legality; each output draws from its
		// APLL's single frequency set
		mmask = ratio_mask_f(st_r.main_khz);                                 // R2
		amask = ratio_mask_f(st_r.aux_khz);
		for (int i = 0; i < NOUT; i++) begin
			code     = st_r.ofreq[4*i +: 4];
			main_fed = !st_r.alt[i] && (code >= 4'h5) && (code <= 4'ha);
			aux_fed  = (!st_r.alt[i] && (code >= 4'hb)) ||
				(st_r.alt[i] && (code == 4'h3));
			ridx     = main_fed ? main_ratio_f(code) : aux_ratio_f(code);
			st_nxt.out_en[i] = (code != 4'h0) &&                             // R12
				!(aux_fed && st_r.aux_pd);                                   // R11
			if (main_fed) begin
				st_nxt.freq_ok[i] = mmask[ridx];                             // R9
			end else if (aux_fed && !st_r.alt[i]) begin
				st_nxt.freq_ok[i] = amask[ridx];                             // R9
			end else begin
				st_nxt.freq_ok[i] = 1'b1;  // Non-APLL or alternate source
			end
		end
	end

	// ----------------------------------------
	// State register
	// ----------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st_r <= RST_S;
		end else begin
			st_r <= st_nxt;
		end
	end

	// ----------------------------------------
	// Outputs straight from the state register, except hresp, which is tied to OKAY
	// ----------------------------------------
	assign hreadyout           = st_r.hready;
	assign hresp               = 1'b0;
	assign hrdata              = st_r.hrdata;
	assign out_enable          = st_r.out_en;
	assign out_freq_ok         = st_r.freq_ok;
	assign aux_apll_power_down = st_r.aux_pd;
	assign main_apll_khz       = st_r.main_khz;
	assign main_dfs_khz        = st_r.main_dfs_khz;
	assign aux_apll_khz        = st_r.aux_khz;
	assign aux_dfs_khz         = st_r.aux_dfs_khz;
	assign apll2_khz           = st_r.apll2_khz;
	assign synth_a_khz         = st_r.syn_a_khz;
	assign synth_b_khz         = st_r.syn_b_khz;

endmodule

// ===== tb/ocfs_props.sv
`timescale 1ns/1ps
`include "ocfs_defs.svh"

module ocfs_props #(
	parameter int NOUT = 7
) (
	// Clock and reset
	input wire logic                   hclk,
	input wire logic                   hresetn,
	// Bus side
	input wire logic                   hsel,
	input wire logic [31:0]            haddr,
	input wire logic [1:0]             htrans,
	input wire logic                   hwrite,
	input wire logic [2:0]             hsize,
	input wire logic [31:0]            hwdata,
	input wire logic                   hready,
	input wire logic                   hreadyout,
	input wire logic                   hresp,
	input wire logic [31:0]            hrdata,
	// Output control
	input wire logic [NOUT-1:0]        out_enable,
	input wire logic [NOUT-1:0]        out_freq_ok,
	input wire logic                   aux_apll_power_down,
	// Decoded frequencies
	input wire logic [`OCFS_KHZ_W-1:0] main_apll_khz,
	input wire logic [`OCFS_KHZ_W-1:0] main_dfs_khz,
	input wire logic [`OCFS_KHZ_W-1:0] aux_apll_khz,
	input wire logic [`OCFS_KHZ_W-1:0] aux_dfs_khz,
	input wire logic [`OCFS_KHZ_W-1:0] apll2_khz,
	input wire logic [`OCFS_KHZ_W-1:0] synth_a_khz,
	input wire logic [`OCFS_KHZ_W-1:0] synth_b_khz
);
	// ----------------------------------------
	// Clocking
	// ----------------------------------------
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	// Source settled over two edges, so the lagging DFS stage has caught up
	sequence s_held(logic [`OCFS_KHZ_W-1:0] v);
		$stable(v) ##1 $stable(v);
	endsequence

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	a_bus_zero_wait: assert property (hreadyout && !hresp)
		else $error("slave not ready or not okay");
	a_apll2_fixed: assert property ($past(hresetn) |-> apll2_khz == `OCFS_K312500)
		else $error("second main apll not at fixed rate");
	a_main_code_set: assert property ($past(hresetn) |-> main_apll_khz inside
		{`OCFS_K311040, `OCFS_K98304, `OCFS_K131072, `OCFS_K148224,
		`OCFS_K98816, `OCFS_K100992, `OCFS_K250000})
		else $error("main apll frequency outside its set");
	a_main_dfs_qtr: assert property (s_held(main_apll_khz) |-> main_dfs_khz == main_apll_khz >> 2)
		else $error("main dfs not a quarter of main apll");
	a_aux_dfs_qtr: assert property (s_held(aux_apll_khz) |-> aux_dfs_khz == aux_apll_khz >> 2)
		else $error("aux dfs not a quarter of aux apll");
	a_aux_pd_zero: assert property (aux_apll_power_down |-> aux_apll_khz == `OCFS_KOFF)
		else $error("powered down aux apll shows a frequency");
	a_synth_a_set: assert property ($past(hresetn) |-> synth_a_khz inside
		{`OCFS_K2048, `OCFS_K2048 << 1, `OCFS_K2048 << 2, `OCFS_K2048 << 3,
		`OCFS_K1544, `OCFS_K1544 << 1, `OCFS_K1544 << 2, `OCFS_K1544 << 3})
		else $error("synth a frequency outside its set");
	a_synth_b_set: assert property ($past(hresetn) |-> synth_b_khz inside
		{`OCFS_K2048, `OCFS_K2048 << 1, `OCFS_K2048 << 2, `OCFS_K2048 << 3,
		`OCFS_K1544, `OCFS_K1544 << 1, `OCFS_K1544 << 2, `OCFS_K1544 << 3,
		`OCFS_K6312, `OCFS_K10000, `OCFS_K19440, `OCFS_K38880, `OCFS_KOFF})
		else $error("synth b frequency outside its set");
endmodule

bind ocfs_top ocfs_props #(.NOUT(NOUT)) u_props (
	.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
	.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
	.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .out_enable(out_enable),
	.out_freq_ok(out_freq_ok), .aux_apll_power_down(aux_apll_power_down),
	.main_apll_khz(main_apll_khz), .main_dfs_khz(main_dfs_khz),
	.aux_apll_khz(aux_apll_khz), .aux_dfs_khz(aux_dfs_khz), .apll2_khz(apll2_khz),
	.synth_a_khz(synth_a_khz), .synth_b_khz(synth_b_khz)
);

// ===== tb/tb_top.sv
`timescale 1ns/1ps
`include "ocfs_defs.svh"

`define CHK(g, e) begin compares++; if ((g) !== (e)) begin n_fail++; \
	$display("Error at %0t got %h expected %h", $time, (g), (e)); end end

module tb_top;
	// ----------------------------------------
	// Signals
	// ----------------------------------------
	logic        hclk, hresetn, hsel, hwrite;   // Clock, reset, controls
	logic [31:0] haddr, hwdata, rd;             // Address, data
	logic [1:0]  htrans;                        // Transfer type
	logic [2:0]  hsize;                         // Always a word
	wire         hready, hreadyout, hresp;      // Single slave ready
	wire  [31:0] hrdata;                        // Read data
	wire  [6:0]  oen, fok;                      // Enables, legality
	wire         pd;                            // Aux power down
	wire  [19:0] mk, mdk, ak, adk, p2k, sak, sbk; // Decoded kHz
	int          n_fail, compares;              // Counters
	logic [19:0] main_tab [8] = '{`OCFS_K311040, `OCFS_K311040, `OCFS_K98304,
		`OCFS_K131072, `OCFS_K148224, `OCFS_K98816, `OCFS_K100992, `OCFS_K250000};

	// Lone slave drives the bus ready
	assign hready = hreadyout;

	ocfs_top #(.NOUT(7)) DUT (
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .out_enable(oen),
		.out_freq_ok(fok), .aux_apll_power_down(pd), .main_apll_khz(mk),
		.main_dfs_khz(mdk), .aux_apll_khz(ak), .aux_dfs_khz(adk), .apll2_khz(p2k),
		.synth_a_khz(sak), .synth_b_khz(sbk)
	);

	// ----------------------------------------
	// Bus tasks
	// ----------------------------------------
	// One single transfer; waits on ready rather than assuming zero wait,
	// so only the watchdog can end a hung bus
	task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] wd);
		hsel   <= 1'b1;
		haddr  <= a;
		hwrite <= w;
		htrans <= 2'b10;
		do @(posedge hclk); while (hready !== 1'b1);
		hsel   <= 1'b0;
		htrans <= 2'b00;
		hwdata <= wd;
		do @(posedge hclk); while (hready !== 1'b1);
		rd = hrdata;
	endtask
	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		xfer(1'b1, a, d);
		// Decode and DFS stages lag the register by two edges
		repeat (3) @(posedge hclk);
	endtask

	// Synth B alternate set, undefined codes read as zero
	function automatic logic [19:0] b_alt(input logic [1:0] m, input logic f);
		case ({m, f})
			3'b000: return `OCFS_K6312;
			3'b100: return `OCFS_K10000;
			3'b001: return `OCFS_K19440;
			3'b011: return `OCFS_K38880;
			default: return `OCFS_KOFF;
		endcase
	endfunction

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	// Reset state of config and decode
	task automatic t_reset;
		for (int a = 0; a <= 'h20; a += 4) begin
			xfer(1'b0, a, 32'h0);
			`CHK(rd, 32'h0)
		end
		`CHK(mk, `OCFS_K311040)
		`CHK(p2k, `OCFS_K312500)
		`CHK({pd, oen}, 8'h80)
		$display("test reset done");
	endtask
	// Every main code and its quarter-rate DFS
	task automatic t_main;
		for (int c = 0; c < 8; c++) begin
			wr(`OCFS_OFF_MAIN, c);
			`CHK(mk, main_tab[c])
			`CHK(mdk, main_tab[c] >> 2)
			xfer(1'b0, `OCFS_OFF_MAINKHZ, 32'h0);
			`CHK(rd, {12'h0, main_tab[c]})
		end
		$display("test main done");
	endtask
	// Both synthesizers over every multiplier, family and alternate bit
	task automatic t_synth;
		logic [19:0] ea;
		for (int al = 0; al < 2; al++)
			for (int f = 0; f < 2; f++)
				for (int m = 0; m < 4; m++) begin
					wr(`OCFS_OFF_MISC6, {al[0], f[0], f[0]});
					wr(`OCFS_OFF_MISC7, {m[1:0], m[1:0]});
					ea = (f ? `OCFS_K1544 : `OCFS_K2048) << m;
					`CHK(sak, ea)
					`CHK(sbk, al ? b_alt(m[1:0], f[0]) : ea)
				end
		$display("test synth done");
	endtask
	// Aux APLL off, own code, then coupled to main
	task automatic t_aux;
		wr(`OCFS_OFF_MAIN, 32'h0);
		wr(`OCFS_OFF_ALT, 32'h0);
		wr(`OCFS_OFF_OUT0, 32'h5b);
		wr(`OCFS_OFF_AUX, 32'h0);
		`CHK({pd, oen[1:0], ak}, {3'b110, `OCFS_KOFF})
		`CHK(fok[1:0], 2'b10)
		wr(`OCFS_OFF_AUX, 32'h1);
		`CHK({pd, oen[1:0], ak, adk}, {3'b011, `OCFS_K311040, `OCFS_K311040 >> 2})
		`CHK(fok[1:0], 2'b11)
		wr(`OCFS_OFF_AUX, 32'h0);
		wr(`OCFS_OFF_MAIN, 32'h48);
		`CHK({pd, oen[1:0], ak}, {3'b011, `OCFS_K250000})
		`CHK(fok[1:0], 2'b10)
		xfer(1'b0, `OCFS_OFF_MAIN, 32'h0);
		`CHK(rd, 32'h48)
		$display("test aux done");
	endtask
	// Code zero disables whatever the alternate bit; alt aux output follows power down
	task automatic t_outs;
		wr(`OCFS_OFF_MAIN, 32'h0);
		wr(`OCFS_OFF_ALT, 32'h7f);
		wr(`OCFS_OFF_OUT0, 32'h50);
		wr(`OCFS_OFF_OUT3, 32'h3);
		`CHK({pd, oen[6], oen[1:0]}, 4'b1010)
		xfer(1'b0, `OCFS_OFF_STAT, 32'h0);
		`CHK(rd[7:0], {pd, oen})
		`CHK(rd[14:8], 7'h7f)
		wr(`OCFS_OFF_AUX, 32'h1);
		`CHK({pd, oen[6]}, 2'b01)
		$display("test outputs done");
	endtask
	// Read-only write ignored, unmapped read zero, second reset mid-run
	task automatic t_bus;
		wr(`OCFS_OFF_MAIN, 32'h7);
		wr(`OCFS_OFF_MAINKHZ, 32'hffffffff);
		xfer(1'b0, `OCFS_OFF_MAINKHZ, 32'h0);
		`CHK(rd, {12'h0, `OCFS_K250000})
		xfer(1'b0, 32'h40, 32'h0);
		`CHK(rd, 32'h0)
		hresetn <= 1'b0;
		repeat (3) @(posedge hclk);
		hresetn <= 1'b1;
		repeat (4) @(posedge hclk);
		`CHK({mk, p2k}, {`OCFS_K311040, `OCFS_K312500})
		$display("test bus done");
	endtask

	// ----------------------------------------
	// Verdict, clock, watchdog, main
	// ----------------------------------------
	task automatic print_verdict;
		$display("fails %0d compares %0d", n_fail, compares);
		if (n_fail == 0 && compares > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	initial begin
		hclk = 1'b0;
		forever #2 hclk = ~hclk;
	end

	// Run needs a few hundred cycles; give it ample room
	initial begin
		#200000;
		n_fail++;
		print_verdict();
	end

	initial begin
		n_fail   = 0;
		compares = 0;
		hresetn  = 1'b0;
		hsel     = 1'b0;
		hwrite   = 1'b0;
		haddr    = 32'h0;
		hwdata   = 32'h0;
		htrans   = 2'b00;
		hsize    = 3'b010;
		repeat (8) @(posedge hclk);
		hresetn <= 1'b1;
		repeat (4) @(posedge hclk);
		t_reset();
		t_main();
		t_synth();
		t_aux();
		t_outs();
		t_bus();
		print_verdict();
	end
endmodule
